// file: core/scp_pkg.sv
// constants, types and helpers shared by the serial port configuration block
package scp_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned SCP_CLK_PERIOD_NS   = 10;
	localparam int unsigned SCP_SOFT_RST_NS     = 100;
	localparam int unsigned SCP_SOFT_RST_CYCLES =
		(SCP_SOFT_RST_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam int unsigned SCP_ADDR_W          = 15;
	localparam logic [14:0] SCP_OFS_INTF_CONFIG = 15'h000;
	localparam logic [14:0] SCP_OFS_CATEGORY    = 15'h003;
	localparam logic [14:0] SCP_OFS_ID_LOW      = 15'h004;
	localparam logic [14:0] SCP_OFS_ID_HIGH     = 15'h005;
	localparam logic [14:0] SCP_OFS_GRADE_REV   = 15'h006;
	localparam logic [14:0] SCP_OFS_PAGE        = 15'h008;
	localparam logic [14:0] SCP_OFS_LOCAL_END   = 15'h009;

	// ----------------------------------------------------------------
	// paged ranges
	// ----------------------------------------------------------------
	localparam logic [14:0] SCP_PG0_LO = 15'h013;
	localparam logic [14:0] SCP_PG0_HI = 15'h014;
	localparam logic [14:0] SCP_PG1_LO = 15'h034;
	localparam logic [14:0] SCP_PG1_HI = 15'h03D;
	localparam logic [14:0] SCP_PG2_LO = 15'h110;
	localparam logic [14:0] SCP_PG2_HI = 15'h124;
	localparam logic [14:0] SCP_PG3_LO = 15'h135;
	localparam logic [14:0] SCP_PG3_HI = 15'h14C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SCP_BIT_RESET   = 0;
	localparam int unsigned SCP_BIT_ORDER   = 1;
	localparam int unsigned SCP_BIT_STEP    = 2;
	localparam int unsigned SCP_BIT_SDO_EN  = 3;
	localparam int unsigned SCP_BIT_RD_FLAG = 7;
	localparam logic [3:0]  SCP_RST_INTF    = 4'h0;
	localparam logic [1:0]  SCP_PAGE_NONE   = 2'h0;
	localparam logic [1:0]  SCP_PAGE_CONV0  = 2'h1;
	localparam logic [1:0]  SCP_PAGE_CONV1  = 2'h2;
	localparam logic [1:0]  SCP_PAGE_BOTH   = 2'h3;
	localparam logic [1:0]  SCP_RST_PAGE    = SCP_PAGE_BOTH;

	typedef enum logic [2:0] {
		SCP_PH_INSTR = 3'b001,
		SCP_PH_ADDR  = 3'b010,
		SCP_PH_DATA  = 3'b100
	} scp_phase_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        paged;
		logic [1:0]  conv_wr;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} scp_access_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] scp_rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			scp_rev8[i] = v[7 - i];
		end
	endfunction

	function automatic logic scp_in_paged(input logic [14:0] a);
		scp_in_paged = (a >= SCP_PG0_LO && a <= SCP_PG0_HI) ||
			(a >= SCP_PG1_LO && a <= SCP_PG1_HI) ||
			(a >= SCP_PG2_LO && a <= SCP_PG2_HI) ||
			(a >= SCP_PG3_LO && a <= SCP_PG3_HI);
	endfunction

	function automatic logic [14:0] scp_step(input logic [14:0] a, input logic up);
		scp_step = up ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
	endfunction

endpackage

// file: core/scp_serial_shift.sv
// bit level serial shifter: pin synchronisers, byte assembly and output shifting
`timescale 1ns/100ps
`default_nettype none

module scp_serial_shift (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       sdio_in,
	input  wire logic       lsb_first,
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_byte,
	output logic            frame_start,
	output logic            frame_active,
	output logic            byte_done,
	output logic [7:0]      rx_byte,
	output logic            tx_bit
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sclk_q;
	logic [2:0] csn_q;
	logic [1:0] sdi_q;
	logic [7:0] rx_sr;
	logic [7:0] tx_sr;
	logic [2:0] bit_cnt;
	logic       rise;
	logic       fall;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclk_q <= 3'h0;
			csn_q  <= 3'h7;
			sdi_q  <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk};
			csn_q  <= {csn_q[1:0], cs_n};
			sdi_q  <= {sdi_q[0], sdio_in};
		end
	end

	assign rise         = sclk_q[1] & ~sclk_q[2] & ~csn_q[1];
	assign fall         = ~sclk_q[1] & sclk_q[2] & ~csn_q[1];
	assign frame_start  = ~csn_q[1] & csn_q[2];
	assign frame_active = ~csn_q[1];

	// ----------------------------------------------------------------
	// receive
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_sr     <= 8'h00;
			rx_byte   <= 8'h00;
			bit_cnt   <= 3'h0;
			byte_done <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			if (!frame_active || frame_start) begin
				bit_cnt <= 3'h0;
			end else if (rise) begin
				rx_sr   <= {rx_sr[6:0], sdi_q[1]};
				bit_cnt <= 3'(bit_cnt + 3'h1);
				if (bit_cnt == 3'h7) begin
					// first bit in lands in bit 0 when lsb first
					rx_byte   <= lsb_first ? scp_pkg::scp_rev8({rx_sr[6:0], sdi_q[1]})
						: {rx_sr[6:0], sdi_q[1]};
					byte_done <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit
	// ----------------------------------------------------------------
	// stored pre-oriented so the pin always comes straight off bit 7
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_sr <= 8'h00;
		end else if (tx_load) begin
			tx_sr <= lsb_first ? scp_pkg::scp_rev8(tx_byte) : tx_byte;
		end else if (fall && bit_cnt != 3'h0) begin
			tx_sr <= {tx_sr[6:0], 1'b0};
		end
	end

	assign tx_bit = tx_sr[7];

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_tx_first_bit: assert property (tx_load |=> tx_bit ==
		(lsb_first ? $past(tx_byte[0]) : $past(tx_byte[7])))
		else $error("first output bit does not follow bit order");

endmodule // scp_serial_shift

`default_nettype wire

// file: core/scp_serial_port_config.sv
// serial port front end with interface configuration, identity and converter paging
// ----------------------------------------------------------------
// Summary of operation
// - multibyte transfers step the address up when step bit is one, else down.
// - bit order select one shifts data lsb first both ways, zero msb first.
// - writing one to reset bit starts soft reset; bit clears when reset ends.
// - page 10 reaches converter 1, 11 writes both reads converter 0, 01 converter 0.
// - paging applies only to four fixed address ranges; others pass unpaged.
// - page select comes out of reset as 11.
// - product category code is a fixed read only byte; writes ignored.
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module scp_serial_port_config #(
	parameter int unsigned SOFT_RST_CYCLES  = scp_pkg::SCP_SOFT_RST_CYCLES,
	parameter logic [7:0]  PRODUCT_CATEGORY = 8'hA5, // value arbitrary
	parameter logic [7:0]  PRODUCT_ID_LOW   = 8'h5A, // value arbitrary
	parameter logic [7:0]  PRODUCT_ID_HIGH  = 8'h3C, // value arbitrary
	parameter logic [3:0]  PRODUCT_GRADE    = 4'h2,  // value arbitrary
	parameter logic [3:0]  SILICON_REVISION = 4'h1   // value arbitrary
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             sdio_in,
	output logic                  sdio_out,
	output logic                  sdio_oe_n,
	output logic                  sdo_out,
	output logic                  sdo_oe_n,
	output var scp_pkg::scp_access_t acc,
	input  wire logic [7:0]       rdata_conv0,
	input  wire logic [7:0]       rdata_conv1,
	input  wire logic [7:0]       rdata_other,
	output logic                  soft_reset_out
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (SOFT_RST_CYCLES < 1 || SOFT_RST_CYCLES > 65535) begin : g_chk
		$error("SOFT_RST_CYCLES must be 1 to 65535");
	end

	scp_pkg::scp_phase_t phase;
	logic        frame_start;
	logic        frame_active;
	logic        byte_done;
	logic        tx_load;
	logic        tx_bit;
	logic        reading;
	logic        rd_mode;
	logic        wr_now;
	logic        rd_next;
	logic [7:0]  rx_byte;
	logic [7:0]  tx_byte;
	logic [14:0] addr;
	logic [14:0] next_addr;
	logic        self_clearing_reset_bit;
	logic        bit_order_select;
	logic        address_step_direction;
	logic        serial_output_line_enable;
	logic [1:0]  converter_page;
	logic [15:0] srst_cnt;
	logic [7:0]  intf_config_rd;

	scp_serial_shift u_shift (
		.core_clk     (core_clk),
		.rst          (rst),
		.sclk         (sclk),
		.cs_n         (cs_n),
		.sdio_in      (sdio_in),
		.lsb_first    (bit_order_select),
		.tx_load      (tx_load),
		.tx_byte      (tx_byte),
		.frame_start  (frame_start),
		.frame_active (frame_active),
		.byte_done    (byte_done),
		.rx_byte      (rx_byte),
		.tx_bit       (tx_bit)
	);

	function automatic logic is_local(input logic [14:0] a);
		is_local = a < scp_pkg::SCP_OFS_LOCAL_END;
	endfunction

	function automatic logic [1:0] page_wr_mask(input logic [1:0] pg);
		case (pg)
			scp_pkg::SCP_PAGE_CONV0: page_wr_mask = 2'b01;
			scp_pkg::SCP_PAGE_CONV1: page_wr_mask = 2'b10;
			scp_pkg::SCP_PAGE_BOTH:  page_wr_mask = 2'b11;
			default:                 page_wr_mask = 2'b00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	always_comb begin
		case (phase)
			scp_pkg::SCP_PH_INSTR: next_addr = {rx_byte[6:0], addr[7:0]};
			scp_pkg::SCP_PH_ADDR:  next_addr = {addr[14:8], rx_byte};
			scp_pkg::SCP_PH_DATA:  next_addr = scp_pkg::scp_step(addr, address_step_direction);
			default:               next_addr = addr;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst || frame_start) begin
			phase <= scp_pkg::SCP_PH_INSTR;
		end else if (byte_done) begin
			case (phase)
				scp_pkg::SCP_PH_INSTR: phase <= scp_pkg::SCP_PH_ADDR;
				scp_pkg::SCP_PH_ADDR:  phase <= scp_pkg::SCP_PH_DATA;
				scp_pkg::SCP_PH_DATA:  phase <= scp_pkg::SCP_PH_DATA;
				default:               phase <= scp_pkg::SCP_PH_INSTR;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr    <= 15'h0000;
			rd_mode <= 1'b0;
		end else if (byte_done) begin
			addr <= next_addr;
			if (phase == scp_pkg::SCP_PH_INSTR) begin
				rd_mode <= rx_byte[scp_pkg::SCP_BIT_RD_FLAG];
			end
		end
	end

	assign wr_now  = byte_done && phase == scp_pkg::SCP_PH_DATA && !rd_mode;
	assign rd_next = byte_done && rd_mode &&
		(phase == scp_pkg::SCP_PH_ADDR || phase == scp_pkg::SCP_PH_DATA);

	// ----------------------------------------------------------------
	// access port to the rest of the device
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			acc     <= '0;
			tx_load <= 1'b0;
		end else begin
			acc.wr      <= wr_now && !is_local(addr);
			acc.rd      <= rd_next && !is_local(next_addr);
			acc.conv_wr <= 2'b00;
			tx_load     <= rd_next;
			if (wr_now) begin
				acc.addr  <= addr;
				acc.wdata <= rx_byte;
				acc.paged <= scp_pkg::scp_in_paged(addr);
				if (scp_pkg::scp_in_paged(addr)) begin
					acc.conv_wr <= page_wr_mask(converter_page);
				end
			end else if (rd_next) begin
				acc.addr  <= next_addr;
				acc.paged <= scp_pkg::scp_in_paged(next_addr);
			end
		end
	end

	// ----------------------------------------------------------------
	// read data selection
	// ----------------------------------------------------------------
	assign intf_config_rd = {self_clearing_reset_bit, bit_order_select,
		address_step_direction, serial_output_line_enable,
		serial_output_line_enable, address_step_direction,
		bit_order_select, self_clearing_reset_bit};

	always_comb begin
		tx_byte = 8'h00;
		if (is_local(acc.addr)) begin
			case (acc.addr)
				scp_pkg::SCP_OFS_INTF_CONFIG: tx_byte = intf_config_rd;
				scp_pkg::SCP_OFS_CATEGORY:    tx_byte = PRODUCT_CATEGORY;
				scp_pkg::SCP_OFS_ID_LOW:      tx_byte = PRODUCT_ID_LOW;
				scp_pkg::SCP_OFS_ID_HIGH:     tx_byte = PRODUCT_ID_HIGH;
				scp_pkg::SCP_OFS_GRADE_REV:   tx_byte = {PRODUCT_GRADE, SILICON_REVISION};
				scp_pkg::SCP_OFS_PAGE:        tx_byte = {6'h00, converter_page};
				default:                      tx_byte = 8'h00;
			endcase
		end else if (acc.paged) begin
			case (converter_page)
				scp_pkg::SCP_PAGE_CONV1: tx_byte = rdata_conv1;
				scp_pkg::SCP_PAGE_CONV0: tx_byte = rdata_conv0;
				scp_pkg::SCP_PAGE_BOTH:  tx_byte = rdata_conv0;
				default:                 tx_byte = 8'h00;
			endcase
		end else begin
			tx_byte = rdata_other;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// soft reset returns the settings to defaults, so the serial link
	// falls back to msb first; the host must rewrite them afterwards
	always_ff @(posedge core_clk) begin
		if (rst || self_clearing_reset_bit) begin
			serial_output_line_enable <= scp_pkg::SCP_RST_INTF[scp_pkg::SCP_BIT_SDO_EN];
			address_step_direction    <= scp_pkg::SCP_RST_INTF[scp_pkg::SCP_BIT_STEP];
			bit_order_select          <= scp_pkg::SCP_RST_INTF[scp_pkg::SCP_BIT_ORDER];
		end else if (wr_now && addr == scp_pkg::SCP_OFS_INTF_CONFIG) begin
			serial_output_line_enable <= rx_byte[scp_pkg::SCP_BIT_SDO_EN];
			address_step_direction    <= rx_byte[scp_pkg::SCP_BIT_STEP];
			bit_order_select          <= rx_byte[scp_pkg::SCP_BIT_ORDER];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || self_clearing_reset_bit) begin
			converter_page <= scp_pkg::SCP_RST_PAGE;
		end else if (wr_now && addr == scp_pkg::SCP_OFS_PAGE) begin
			converter_page <= rx_byte[1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			self_clearing_reset_bit <= 1'b0;
			srst_cnt                <= 16'h0000;
		end else if (wr_now && addr == scp_pkg::SCP_OFS_INTF_CONFIG &&
				rx_byte[scp_pkg::SCP_BIT_RESET]) begin
			self_clearing_reset_bit <= 1'b1;
			srst_cnt                <= SOFT_RST_CYCLES[15:0];
		end else if (self_clearing_reset_bit) begin
			if (srst_cnt == 16'h0001) begin
				self_clearing_reset_bit <= 1'b0;
			end
			srst_cnt <= 16'(srst_cnt - 16'h0001);
		end
	end

	assign soft_reset_out = self_clearing_reset_bit;

	// ----------------------------------------------------------------
	// serial output pins
	// ----------------------------------------------------------------
	// three wire mode turns the data line round; four wire keeps it input
	assign reading   = frame_active && rd_mode && phase == scp_pkg::SCP_PH_DATA;
	assign sdio_out  = tx_bit;
	assign sdo_out   = tx_bit;
	assign sdio_oe_n = ~(reading && !serial_output_line_enable);
	assign sdo_oe_n  = ~(reading && serial_output_line_enable);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_addr_step_dir: assert property (
		byte_done && phase == scp_pkg::SCP_PH_DATA |=> addr == ($past(address_step_direction)
			? 15'($past(addr) + 15'h0001) : 15'($past(addr) - 15'h0001)))
		else $error("address did not step in the selected direction");

	a_soft_reset_len: assert property (
		wr_now && addr == scp_pkg::SCP_OFS_INTF_CONFIG && rx_byte[0]
		|=> self_clearing_reset_bit && srst_cnt == SOFT_RST_CYCLES[15:0])
		else $error("soft reset did not start with full count");

	a_soft_reset_end: assert property (
		self_clearing_reset_bit && srst_cnt == 16'h0001 && !wr_now
		|=> !self_clearing_reset_bit && converter_page == scp_pkg::SCP_RST_PAGE)
		else $error("reset bit did not clear at end of soft reset");

	a_page_conv1_wr: assert property (
		wr_now && scp_pkg::scp_in_paged(addr) && converter_page == scp_pkg::SCP_PAGE_CONV1
		|=> acc.wr && acc.conv_wr == 2'b10)
		else $error("page 2 write did not reach converter 1 only");

	a_page_both_rd: assert property (
		tx_load && acc.paged && converter_page == scp_pkg::SCP_PAGE_BOTH
		|-> tx_byte == rdata_conv0)
		else $error("page 3 read did not return converter 0");

	a_unpaged_range: assert property (
		acc.wr && !scp_pkg::scp_in_paged(acc.addr) |-> acc.conv_wr == 2'b00 && !acc.paged)
		else $error("access outside paged ranges was paged");

	a_page_after_rst: assert property (disable iff (1'b0)
		rst ##1 !rst |-> converter_page == scp_pkg::SCP_PAGE_BOTH)
		else $error("page select not 3 after reset");

	a_category_fixed: assert property (
		tx_load && acc.addr == scp_pkg::SCP_OFS_CATEGORY |-> tx_byte == PRODUCT_CATEGORY)
		else $error("category code read wrong");

	a_config_copies: assert property (
		tx_load && acc.addr == scp_pkg::SCP_OFS_INTF_CONFIG
		|-> tx_byte[7:4] == {tx_byte[0], tx_byte[1], tx_byte[2], tx_byte[3]}
			&& tx_byte[3:0] == {serial_output_line_enable, address_step_direction,
			bit_order_select, self_clearing_reset_bit})
		else $error("config copy bits disagree with controls");

	c_read_burst:  cover property (tx_load ##[1:200] tx_load);
	c_write_both:  cover property (acc.wr && acc.conv_wr == 2'b11);
	c_soft_reset:  cover property ($fell(self_clearing_reset_bit));
	c_lsb_first:   cover property (byte_done && bit_order_select);

endmodule // scp_serial_port_config

`default_nettype wire

// file: testbench/scp_host_model.sv
// host serial master model that drives frames into the configuration port
`timescale 1ns/100ps
`default_nettype none

module scp_host_model (
	input  wire logic core_clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	input  wire logic sdo_out,
	input  wire logic sdo_oe_n
);
	// ----------------------------------------------------------------
	// wire levels
	// ----------------------------------------------------------------
	logic       lsb_first = 1'b0;
	logic       use_sdo   = 1'b0;
	logic       drv       = 1'b0;
	logic [7:0] dbuf [8];
	logic       rd_line;

	// a released line shows a changing pattern, so an undriven bit never matches by luck
	assign sdio_in = sdio_oe_n ? drv : sdio_out;
	assign rd_line = use_sdo ? (sdo_oe_n ? ~drv : sdo_out) : sdio_in;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	// ----------------------------------------------------------------
	// frame tasks
	// ----------------------------------------------------------------
	// half periods of 10 cycles leave room for the pin synchronisers
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic bit_io(input logic b, output logic r);
		drv = b;
		sclk = 1'b0;
		wait_cyc(10);
		r = rd_line;
		sclk = 1'b1;
		wait_cyc(10);
	endtask

	task automatic byte_io(input logic [7:0] v, output logic [7:0] r);
		int k;
		for (int i = 0; i < 8; i++) begin
			k = lsb_first ? i : 7 - i;
			bit_io(v[k], r[k]);
		end
	endtask

	task automatic frame(input logic rd, input logic [14:0] a, input int n);
		logic [7:0] t;
		cs_n = 1'b0;
		wait_cyc(10);
		byte_io({rd, a[14:8]}, t);
		byte_io(a[7:0], t);
		for (int i = 0; i < n; i++) begin
			byte_io(rd ? 8'h55 : dbuf[i], t);
			if (rd)
				dbuf[i] = t;
		end
		sclk = 1'b0;
		wait_cyc(10);
		cs_n = 1'b1;
		wait_cyc(10);
	endtask
endmodule // scp_host_model

`default_nettype wire

// file: testbench/serial_port_config_and_paging_tb.sv
// self-checking bench for the serial port configuration and paging block
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end

module serial_port_config_and_paging_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int SRC = 3;
	logic                 core_clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 sclk;
	logic                 cs_n;
	logic                 sdio_in;
	logic                 sdio_out;
	logic                 sdio_oe_n;
	logic                 sdo_out;
	logic                 sdo_oe_n;
	logic                 soft_reset_out;
	logic [7:0]           rdata_conv0 = 8'h00;
	logic [7:0]           rdata_conv1 = 8'h00;
	logic [7:0]           rdata_other = 8'h00;
	scp_pkg::scp_access_t acc;
	scp_pkg::scp_access_t wq [$];
	logic [31:0]          seed = 32'h8A7F4DB8;
	int                   num_errors = 0;
	int                   samples_checked = 0;
	int                   srcnt = 0;
	logic                 rd_seen = 1'b0;
	logic                 rd_pg;
	logic [14:0]          rd_a;
	logic [14:0]          pg_tab [11] = '{15'h012, 15'h013, 15'h014, 15'h015, 15'h034,
		15'h03D, 15'h110, 15'h124, 15'h135, 15'h14C, 15'h14D};

	always #5 core_clk = ~core_clk;

	scp_serial_port_config #(.SOFT_RST_CYCLES(SRC)) dut_u (
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
		.acc(acc), .rdata_conv0(rdata_conv0), .rdata_conv1(rdata_conv1),
		.rdata_other(rdata_other), .soft_reset_out(soft_reset_out)
	);

	scp_host_model host_u (
		.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n)
	);

	// ----------------------------------------------------------------
	// expectations and neighbours
	// ----------------------------------------------------------------
	function automatic logic [7:0] f_dat(input int s, input logic [14:0] a);
		f_dat = a[7:0] ^ (s == 0 ? 8'h3C : (s == 1 ? 8'hC3 : 8'h96));
	endfunction

	function automatic logic in_pg(input logic [14:0] a);
		in_pg = (a >= 15'h013 && a <= 15'h014) || (a >= 15'h034 && a <= 15'h03D) ||
			(a >= 15'h110 && a <= 15'h124) || (a >= 15'h135 && a <= 15'h14C);
	endfunction

	function automatic logic [7:0] exp_rd(input logic [14:0] a, input logic [1:0] p);
		if (!in_pg(a))
			exp_rd = f_dat(2, a);
		else if (p == 2'h0)
			exp_rd = 8'h00;
		else
			exp_rd = f_dat(p == 2'h2 ? 1 : 0, a);
	endfunction

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		rnd = seed[7:0];
	endfunction

	// distinct data per converter so a wrong route shows up
	always @(negedge core_clk) begin
		rdata_conv0 <= f_dat(0, acc.addr);
		rdata_conv1 <= f_dat(1, acc.addr);
		rdata_other <= f_dat(2, acc.addr);
	end

	always @(posedge core_clk) begin
		if (acc.wr === 1'b1)
			wq.push_back(acc);
		if (soft_reset_out === 1'b1)
			srcnt++;
		// first forwarded read of a frame is the addressed one; later ones prefetch
		if (acc.rd === 1'b1 && !rd_seen) begin
			rd_seen = 1'b1;
			rd_pg   = acc.paged;
			rd_a    = acc.addr;
		end
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr1(input logic [14:0] a, input logic [7:0] d);
		host_u.dbuf[0] = d;
		host_u.frame(1'b0, a, 1);
	endtask

	task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
		rd_seen = 1'b0;
		host_u.frame(1'b1, a, 1);
		`CHK(host_u.dbuf[0], e)
		if (a >= 15'h009)
			`CHK({rd_seen, rd_pg, rd_a}, {1'b1, in_pg(a), a})
	endtask

	task automatic wr_chk(input logic [14:0] a, input logic [1:0] p);
		logic [7:0] d;
		logic [1:0] cw;
		d = rnd();
		cw = in_pg(a) ? p : 2'h0;
		wq.delete();
		wr1(a, d);
		`CHK(wq.size(), 1)
		`CHK({wq[0].paged, wq[0].conv_wr, wq[0].addr, wq[0].wdata}, {in_pg(a), cw, a, d})
	endtask

	task automatic step_chk(input logic up);
		logic [14:0] ea;
		wr1(15'h000, up ? 8'h24 : 8'h00);
		rd_chk(15'h000, up ? 8'h24 : 8'h00);
		for (int i = 0; i < 3; i++)
			host_u.dbuf[i] = rnd();
		wq.delete();
		host_u.frame(1'b0, 15'h020, 3);
		for (int i = 0; i < 3; i++) begin
			ea = up ? 15'h020 + 15'(i) : 15'h020 - 15'(i);
			`CHK({wq[i].addr, wq[i].wdata}, {ea, host_u.dbuf[i]})
		end
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		rd_chk(15'h000, 8'h00);
		rd_chk(15'h008, 8'h03);
		wr_chk(15'h013, 2'h3);
		rd_chk(15'h003, 8'hA5);
		wr1(15'h003, 8'h5A);
		rd_chk(15'h003, 8'hA5);
		rd_chk(15'h004, 8'h5A);
		rd_chk(15'h005, 8'h3C);
		rd_chk(15'h006, 8'h21);
		for (int p = 0; p < 4; p++) begin
			wr1(15'h008, 8'(p));
			for (int i = 0; i < 11; i++) begin
				wr_chk(pg_tab[i], 2'(p));
				rd_chk(pg_tab[i], exp_rd(pg_tab[i], 2'(p)));
			end
		end
		step_chk(1'b1);
		step_chk(1'b0);
		// downward read through address zero wraps to the top of the space
		host_u.frame(1'b1, 15'h001, 3);
		`CHK({host_u.dbuf[0], host_u.dbuf[1], host_u.dbuf[2]}, {16'h0000, f_dat(2, 15'h7FFF)})
		wr1(15'h000, 8'h02);
		host_u.lsb_first = 1'b1;
		rd_chk(15'h000, 8'h42);
		rd_chk(15'h004, 8'h5A);
		wr_chk(15'h013, 2'h3);
		wr1(15'h000, 8'h00);
		host_u.lsb_first = 1'b0;
		rd_chk(15'h000, 8'h00);
		wr1(15'h000, 8'h08);
		host_u.use_sdo = 1'b1;
		rd_chk(15'h000, 8'h18);
		rd_chk(15'h005, 8'h3C);
		wr1(15'h000, 8'h00);
		host_u.use_sdo = 1'b0;
		wr1(15'h008, 8'h02);
		wr1(15'h000, 8'h04);
		srcnt = 0;
		wr1(15'h000, 8'h01);
		`CHK(srcnt, SRC)
		rd_chk(15'h000, 8'h00);
		rd_chk(15'h008, 8'h03);
		test_done();
	end

	// about 65k cycles of frames are expected
	initial begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		test_done();
	end
endmodule // serial_port_config_and_paging_tb

`default_nettype wire
